// ==== hdl/mnidc_pkg.sv ====
// Package of offsets, field values and reset values for the ID register bank.
package mnidc_pkg;

    // ********************************************************************
    // Register offsets (byte addresses on the Wishbone bus)
    // ********************************************************************
    localparam logic [7:0] OFS_OCR = 8'h00;
    localparam logic [7:0] OFS_CID_BASE = 8'h10;
    localparam logic [7:0] OFS_CSD_BASE = 8'h20;
    localparam logic [7:0] OFS_SEC_COUNT = 8'h30;
    localparam logic [7:0] OFS_ENH_SIZE = 8'h34;
    localparam logic [7:0] OFS_BUS_WIDTH = 8'h38;
    localparam logic [7:0] OFS_CTRL = 8'h3C;
    localparam logic [7:0] OFS_STATUS = 8'h40;

    // ********************************************************************
    // Operating-conditions fields
    // ********************************************************************
    localparam logic [1:0] OCR_ACCESS_SECTOR = 2'h2;
    localparam logic [8:0] OCR_HIGH_WINDOW = 9'h1FF;
    localparam logic OCR_LOW_WINDOW = 1'b1;

    // ********************************************************************
    // Identity fields
    // ********************************************************************
    localparam logic [1:0] CID_PACKAGE_BGA = 2'h1;
    localparam logic [7:0] CID_REVISION = 8'h00;

    // ********************************************************************
    // Card-specific-data fixed fields
    // ********************************************************************
    localparam logic [1:0] STRUCTURE_CODE_CODE = 2'h3;
    localparam logic [3:0] CSD_SPEC_VERSION = 4'h4;
    localparam logic [7:0] CSD_ACCESS_TIME = 8'h0E;
    localparam logic [7:0] CSD_CLOCK_ACCESS = 8'h00;
    localparam logic [7:0] CSD_MAX_CLOCK = 8'h32;
    localparam logic [11:0] CSD_CMD_CLASSES = 12'h0F5;
    localparam logic [3:0] CSD_BLOCK_LEN = 4'h9;
    localparam logic CSD_PARTIAL_FLAG = 1'b0;
    localparam logic CSD_MISALIGN_FLAG = 1'b0;
    localparam logic CSD_DRIVER_STAGE = 1'b0;
    localparam logic [11:0] CSD_LEGACY_SIZE = 12'hFFF;
    localparam logic [2:0] CSD_CURRENT_CODE = 3'h7;
    localparam logic [2:0] CSD_SIZE_MULT = 3'h7;
    localparam logic [4:0] CSD_ERASE_GROUP = 5'h1F;
    localparam logic [4:0] CSD_ERASE_MULT = 5'h1F;
    localparam logic [4:0] CSD_PROTECT_SIZE = 5'h0F;
    localparam logic CSD_PROTECT_ENABLE = 1'b1;
    localparam logic [1:0] CSD_DEFAULT_ECC = 2'h0;
    localparam logic [2:0] CSD_WRITE_SPEED = 3'h4;
    localparam logic CSD_CONTENT_PROT = 1'b0;

    // ********************************************************************
    // Capacity, bus width, control bits and checksum parameters
    // ********************************************************************
    localparam logic [31:0] SEC_COUNT_FULL = 32'h00E9_0000;
    localparam logic [1:0] BUS_WIDTH_1 = 2'h0;
    localparam logic [1:0] BUS_WIDTH_BAD = 2'h3;
    localparam int CTRL_ERASE_BIT = 0;
    localparam logic [6:0] CRC7_POLY = 7'h09;
    localparam int CRC7_BODY_BITS = 120;

endpackage

// ==== hdl/mnidc_crc7.sv ====
// Registered seven-bit checksum over a wide word, most significant bit first.
module mnidc_crc7 #(
    parameter int WIDTH = 120
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] body,
    output logic [6:0] crc
);

    logic [6:0] crc_nxt;

    // The whole word is folded in one cycle; the result lags the body by one
    // clock, which the bus read path hides because a read takes a cycle.
    always_comb begin
        logic fb;
        fb = 1'b0;
        crc_nxt = 7'h00;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            fb = body[i] ^ crc_nxt[6];
            crc_nxt = {crc_nxt[5:0], 1'b0};
            if (fb) begin
                crc_nxt = crc_nxt ^ mnidc_pkg::CRC7_POLY;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= 7'h00;
        end else begin
            crc <= crc_nxt;
        end
    end

endmodule

// ==== hdl/mnidc_regs.sv ====
// Identification and capability register bank with a Wishbone slave port.
//
// Notes on behaviour
// RULE1: Power-up busy bit 31 reads low until the power-up count completes.
// RULE2: Voltage windows: bit 7 set, bits 14..8 clear, bits 23..15 all set.
// RULE3: Access mode bits 30..29 read 10b; reserved bits read zero.
// RULE4: Identity word carries a seven-bit checksum in bits 7..1, bit 0 one.
// RULE5: Identity holds maker, application, name, revision, serial and date.
// RULE6: Package field reads 01b for a ball-grid part; bits 119..114 zero.
// RULE7: Structure code 3 and specification version 4 in the top bits.
// RULE8: Access time 0x0E, clock access time 0x00, maximum clock code 0x32.
// RULE9: Command classes advertised as 0x0F5 in bits 95..84.
// RULE10: Block lengths 512 bytes; partial and misaligned access flags clear.
// RULE11: Legacy size 0xFFF, multiplier 7; capacity lives in sector count.
// RULE12: Sector count 0x00E90000, reduced by the enhanced user area size.
// RULE13: Erase group fields 0x1F, protect group size 0x0F, enable set.
// RULE14: Write speed factor 4, default ECC 0, no driver stage register.
// RULE15: All four supply-current codes read 7.
// RULE16: Format, copy and protect bits programmable; some bits erasable.
// RULE17: Checksum in bits 7..1 programmable, bit 0 one, bits 20..17 zero.
// RULE18: Data path runs on one, four or eight lines as the host selects.
// RULE19: Checksums use polynomial x^7 + x^3 + 1 over higher bits, MSB first.
module mnidc_regs #(
    parameter int POWERUP_CYCLES = 1000,
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] APP_CODE = 8'h00,
    parameter logic [47:0] PRODUCT_NAME = 48'h4E41_4E44_3132,
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
    parameter logic [7:0] MFG_DATE = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [1:0] bus_width_o,
    output logic ready_o
);

    // MAKER_CODE and PRODUCT_NAME defaults are arbitrary neutral values.

    // ********************************************************************
    // Bus decode
    // ********************************************************************
    logic access;
    logic wr;
    logic [7:0] adr_w;
    logic crc_ok_r;

    // The checksum registers still hold their reset zero at the first edge
    // after reset, so no request is taken before they have folded once.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_ok_r <= 1'b0;
        end else begin
            crc_ok_r <= 1'b1; // [RULE4]
        end
    end

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && crc_ok_r;
    assign wr = access && wb_we_i;
    assign adr_w = {wb_adr_i[7:2], 2'b00};

    // ********************************************************************
    // Power-up routine
    // ********************************************************************
    logic [15:0] pu_cnt_r;
    logic powered_r;
    localparam logic [15:0] PU_LAST = 16'(POWERUP_CYCLES - 1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_r <= 16'h0000;
            powered_r <= 1'b0;
        end else if (!powered_r) begin
            if (pu_cnt_r == PU_LAST) begin
                powered_r <= 1'b1; // [RULE1]
            end else begin
                pu_cnt_r <= pu_cnt_r + 16'h0001;
            end
        end
    end

    // ********************************************************************
    // Host-programmable card-specific-data bits
    // ********************************************************************
    logic ffg_r;
    logic copy_r;
    logic perm_r;
    logic tmp_r;
    logic [1:0] ffmt_r;
    logic [1:0] ecc_r;
    logic [6:0] crc_ovr_r;
    logic crc_set_r;
    logic erase;

    assign erase = wr && adr_w == mnidc_pkg::OFS_CTRL && wb_sel_i[0]
        && wb_dat_i[mnidc_pkg::CTRL_ERASE_BIT];

    // Copy and permanent protection are one-time bits: once set they stay
    // set until reset, so a later write of zero cannot undo a protection.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ffg_r <= 1'b0;
            copy_r <= 1'b0;
            perm_r <= 1'b0;
            tmp_r <= 1'b0;
            ffmt_r <= 2'h0;
            ecc_r <= 2'h0;
        end else if (erase) begin
            tmp_r <= 1'b0; // [RULE16]
            ecc_r <= 2'h0; // [RULE16]
        end else if (wr && adr_w == mnidc_pkg::OFS_CSD_BASE && wb_sel_i[1]) begin
            ffg_r <= wb_dat_i[15]; // [RULE16]
            copy_r <= copy_r | wb_dat_i[14]; // [RULE16]
            perm_r <= perm_r | wb_dat_i[13]; // [RULE16]
            tmp_r <= wb_dat_i[12];
            ffmt_r <= wb_dat_i[11:10];
            ecc_r <= wb_dat_i[9:8];
        end
    end

    // Until the host programs it, the checksum field follows the computed
    // value; erasing returns it to the computed value.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_ovr_r <= 7'h00;
            crc_set_r <= 1'b0;
        end else if (erase) begin
            crc_set_r <= 1'b0; // [RULE16]
        end else if (wr && adr_w == mnidc_pkg::OFS_CSD_BASE && wb_sel_i[0]) begin
            crc_ovr_r <= wb_dat_i[7:1]; // [RULE17]
            crc_set_r <= 1'b1;
        end
    end

    // ********************************************************************
    // Data-line width selection
    // ********************************************************************
    logic [1:0] bus_width_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_width_r <= mnidc_pkg::BUS_WIDTH_1;
        end else if (wr && adr_w == mnidc_pkg::OFS_BUS_WIDTH && wb_sel_i[0]
                && wb_dat_i[1:0] != mnidc_pkg::BUS_WIDTH_BAD) begin
            bus_width_r <= wb_dat_i[1:0]; // [RULE18]
        end
    end

    // ********************************************************************
    // Enhanced user area and capacity
    // ********************************************************************
    logic [31:0] enh_size_r;
    logic [31:0] sec_count_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enh_size_r <= 32'h0000_0000;
        end else if (wr && adr_w == mnidc_pkg::OFS_ENH_SIZE) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    enh_size_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // An enhanced area larger than the device leaves no plain user area.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_count_r <= mnidc_pkg::SEC_COUNT_FULL;
        end else if (enh_size_r <= mnidc_pkg::SEC_COUNT_FULL) begin
            sec_count_r <= mnidc_pkg::SEC_COUNT_FULL - enh_size_r; // [RULE12]
        end else begin
            sec_count_r <= 32'h0000_0000;
        end
    end

    // ********************************************************************
    // Register images
    // ********************************************************************
    logic [31:0] ocr_value;
    logic [119:0] cid_body;
    logic [119:0] csd_body;
    logic [6:0] cid_crc;
    logic [6:0] csd_crc;
    logic [6:0] csd_crc_out;
    logic [127:0] cid_value;
    logic [127:0] csd_value;

    assign ocr_value = {powered_r, mnidc_pkg::OCR_ACCESS_SECTOR, // [RULE1]
        5'h00, mnidc_pkg::OCR_HIGH_WINDOW, 7'h00, // [RULE2] [RULE3]
        mnidc_pkg::OCR_LOW_WINDOW, 7'h00}; // [RULE2] [RULE3]

    assign cid_body = {MAKER_CODE, 6'h00, mnidc_pkg::CID_PACKAGE_BGA, // [RULE6]
        APP_CODE, PRODUCT_NAME, mnidc_pkg::CID_REVISION, // [RULE5]
        SERIAL_NUMBER, MFG_DATE}; // [RULE5]

    assign csd_body = {mnidc_pkg::STRUCTURE_CODE_CODE, // [RULE7]
        mnidc_pkg::CSD_SPEC_VERSION, 2'h0, // [RULE7]
        mnidc_pkg::CSD_ACCESS_TIME, mnidc_pkg::CSD_CLOCK_ACCESS, // [RULE8]
        mnidc_pkg::CSD_MAX_CLOCK, mnidc_pkg::CSD_CMD_CLASSES, // [RULE8] [RULE9]
        mnidc_pkg::CSD_BLOCK_LEN, mnidc_pkg::CSD_PARTIAL_FLAG, // [RULE10]
        mnidc_pkg::CSD_MISALIGN_FLAG, mnidc_pkg::CSD_MISALIGN_FLAG, // [RULE10]
        mnidc_pkg::CSD_DRIVER_STAGE, 2'h0, // [RULE14]
        mnidc_pkg::CSD_LEGACY_SIZE, // [RULE11]
        {4{mnidc_pkg::CSD_CURRENT_CODE}}, // [RULE15]
        mnidc_pkg::CSD_SIZE_MULT, // [RULE11]
        mnidc_pkg::CSD_ERASE_GROUP, mnidc_pkg::CSD_ERASE_MULT, // [RULE13]
        mnidc_pkg::CSD_PROTECT_SIZE, mnidc_pkg::CSD_PROTECT_ENABLE, // [RULE13]
        mnidc_pkg::CSD_DEFAULT_ECC, mnidc_pkg::CSD_WRITE_SPEED, // [RULE14]
        mnidc_pkg::CSD_BLOCK_LEN, mnidc_pkg::CSD_PARTIAL_FLAG, // [RULE10]
        4'h0, mnidc_pkg::CSD_CONTENT_PROT, // [RULE17]
        ffg_r, copy_r, perm_r, tmp_r, ffmt_r, ecc_r}; // [RULE16]

    mnidc_crc7 #(
        .WIDTH(mnidc_pkg::CRC7_BODY_BITS)
    ) u_cid_crc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .body(cid_body),
        .crc(cid_crc)
    ); // [RULE19]

    mnidc_crc7 #(
        .WIDTH(mnidc_pkg::CRC7_BODY_BITS)
    ) u_csd_crc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .body(csd_body),
        .crc(csd_crc)
    ); // [RULE19]

    assign csd_crc_out = crc_set_r ? crc_ovr_r : csd_crc; // [RULE17]
    assign cid_value = {cid_body, cid_crc, 1'b1}; // [RULE4]
    assign csd_value = {csd_body, csd_crc_out, 1'b1}; // [RULE17]

    // ********************************************************************
    // Read path and acknowledge
    // ********************************************************************
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (adr_w)
            mnidc_pkg::OFS_OCR: rd_nxt = ocr_value;
            mnidc_pkg::OFS_CID_BASE: rd_nxt = cid_value[31:0];
            mnidc_pkg::OFS_CID_BASE + 8'h04: rd_nxt = cid_value[63:32];
            mnidc_pkg::OFS_CID_BASE + 8'h08: rd_nxt = cid_value[95:64];
            mnidc_pkg::OFS_CID_BASE + 8'h0C: rd_nxt = cid_value[127:96];
            mnidc_pkg::OFS_CSD_BASE: rd_nxt = csd_value[31:0];
            mnidc_pkg::OFS_CSD_BASE + 8'h04: rd_nxt = csd_value[63:32];
            mnidc_pkg::OFS_CSD_BASE + 8'h08: rd_nxt = csd_value[95:64];
            mnidc_pkg::OFS_CSD_BASE + 8'h0C: rd_nxt = csd_value[127:96];
            mnidc_pkg::OFS_SEC_COUNT: rd_nxt = sec_count_r;
            mnidc_pkg::OFS_ENH_SIZE: rd_nxt = enh_size_r;
            mnidc_pkg::OFS_BUS_WIDTH: rd_nxt = {30'h0000_0000, bus_width_r};
            mnidc_pkg::OFS_STATUS: begin
                rd_nxt = {28'h000_0000, crc_set_r, bus_width_r, powered_r};
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Every address is acknowledged so a stray access never hangs the bus;
    // unmapped reads return zero and unmapped writes are dropped.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_width_o <= mnidc_pkg::BUS_WIDTH_1;
            ready_o <= 1'b0;
        end else begin
            bus_width_o <= bus_width_r;
            ready_o <= powered_r;
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    localparam logic [31:0] CSD_TOP_WORD = 32'hD00E_0032;

    sequence s_rd_done(logic [7:0] a);
        wb_ack_o && !wb_we_i && adr_w == a;
    endsequence

    sequence s_wr_req(logic [7:0] a);
        wr && adr_w == a;
    endsequence

    a_busy_bit_read: assert property ( // [RULE1]
        s_rd_done(mnidc_pkg::OFS_OCR) |-> wb_dat_o[31] == $past(powered_r))
        else $error("busy bit does not follow power-up state");

    a_busy_rise_time: assert property ( // [RULE1]
        $rose(powered_r) |-> $past(pu_cnt_r) == PU_LAST)
        else $error("power-up finished at the wrong count");

    a_ocr_fixed_bits: assert property ( // [RULE2]
        s_rd_done(mnidc_pkg::OFS_OCR) |-> wb_dat_o[30:0] == 31'h40FF_8080)
        else $error("operating conditions fixed bits wrong");

    a_cid_crc_word: assert property ( // [RULE4]
        s_rd_done(mnidc_pkg::OFS_CID_BASE)
        |-> wb_dat_o[7:0] == {$past(cid_crc), 1'b1})
        else $error("identity checksum byte wrong");

    a_csd_top_word: assert property ( // [RULE7]
        s_rd_done(mnidc_pkg::OFS_CSD_BASE + 8'h0C) |-> wb_dat_o == CSD_TOP_WORD)
        else $error("card data top word wrong");

    a_width_bad_kept: assert property ( // [RULE18]
        (s_wr_req(mnidc_pkg::OFS_BUS_WIDTH)
        and wb_dat_i[1:0] == mnidc_pkg::BUS_WIDTH_BAD)
        |=> $stable(bus_width_r) ##1 bus_width_o == $past(bus_width_r, 2))
        else $error("invalid width code changed the width");

    a_erase_clears: assert property ( // [RULE16]
        erase |=> !tmp_r && ecc_r == 2'h0 && !crc_set_r)
        else $error("erase left erasable bits set");

    a_otp_sticky: assert property ( // [RULE16]
        (copy_r || perm_r)
        |=> $past(copy_r) <= copy_r && $past(perm_r) <= perm_r)
        else $error("one-time bit was cleared");

    a_sector_count: assert property ( // [RULE12]
        (enh_size_r <= mnidc_pkg::SEC_COUNT_FULL)
        |=> sec_count_r == mnidc_pkg::SEC_COUNT_FULL - $past(enh_size_r))
        else $error("sector count not reduced by enhanced area");

    a_ack_timing: assert property (
        access |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not one cycle after request");

endmodule

// ==== tb/mnidc_host.sv ====
// Host-side Wishbone classic master model that drives the register bank.
module mnidc_host (
    input wire logic sys_clk,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [7:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
    end

    // ********************************************************************
    // Single classic cycle
    // ********************************************************************
    // The request is held until ack is sampled high; the slave's latency is
    // never assumed, so only the bench timeout can end a stuck wait.
    // Used for every read and write, programming and width selection included
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [3:0] sel, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge sys_clk);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // Released lines show the inverse so stale values are never trusted.
        wb_adr_i <= ~adr;
        wb_sel_i <= ~sel;
        wb_dat_i <= ~wdat;
    endtask
endmodule

// ==== tb/test_mnidc_regs.sv ====
// Self-checking bench for the identification register bank.
module test_mnidc_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************************************************
    // Bench state
    // ********************************************************************
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
    localparam logic [47:0] NAME = 48'h4E41_4E44_3132; // Arbitrary value.
    localparam logic [31:0] SERIAL = 32'h0000_0001;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc, stb, we, ack, ready;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [1:0] bus_width;
    logic [1:0] width;
    logic [127:0] v;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    mnidc_regs #(.POWERUP_CYCLES(10), .MAKER_CODE(MAKER), .APP_CODE(8'h00),
        .PRODUCT_NAME(NAME), .SERIAL_NUMBER(SERIAL), .MFG_DATE(8'h00)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bus_width_o(bus_width),
        .ready_o(ready));

    mnidc_host host (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(rdat),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat));

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [6:0] crc7(input logic [119:0] body);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = body[i] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ 7'h09;
            end
        end
        return c;
    endfunction

    function automatic logic [127:0] with_crc(input logic [127:0] x);
        return {x[127:8], crc7(x[127:8]), 1'b1};
    endfunction

    // Byte b is the host-programmable field in bits 15..8.
    function automatic logic [127:0] card_specific_data(input logic [7:0] b);
        return with_crc({32'hD00E_0032, 32'h0F59_03FF, 32'hFFFF_FFEF,
                         16'h9240, b, 8'h00});
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.access(1'b0, a, 4'h0, 32'h0000_0000, d);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        logic [31:0] dummy;
        host.access(1'b1, a, s, d, dummy);
    endtask

    task automatic reg_chk(input logic [7:0] base, input logic [127:0] e);
        for (int i = 0; i < 4; i++) begin
            rd_chk(base + 8'(4 * i), e[32 * i +: 32]);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The ceiling is over ten times the expected run of under two hundred cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    // ********************************************************************
    // Tests
    // ********************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(8'h00, 32'h40FF_8080);
        check({31'h0000_0000, ready}, 32'h0000_0000);
        for (int i = 0; i < 50 && ready !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        rd_chk(8'h00, 32'hC0FF_8080);
        rd_chk(8'h40, 32'h0000_0001);
        wr(8'h00, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h00, 32'hC0FF_8080);
        wr(8'h80, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0000_0000);
        $display("test power_up done");

        v = {MAKER, 6'h00, 2'b01, 8'h00, NAME, 8'h00, SERIAL, 16'h0000};
        reg_chk(8'h10, with_crc(v));
        wr(8'h2C, 4'hF, 32'h0000_0000);
        reg_chk(8'h20, card_specific_data(8'h00));
        reg_chk(8'h20, card_specific_data(8'h00));
        rd_chk(8'h30, 32'h00E9_0000);
        $display("test fixed_contents done");

        wr(8'h34, 4'h1, 32'hFFFF_FFFF);
        rd_chk(8'h30, 32'h00E8_FF01);
        wr(8'h34, 4'hF, 32'h0100_0000);
        rd_chk(8'h30, 32'h0000_0000);
        wr(8'h34, 4'hF, 32'h0000_0000);
        rd_chk(8'h30, 32'h00E9_0000);
        $display("test capacity done");

        // Code 3 is not a width, so the previous choice must survive it.
        width = 2'h0;
        for (int c = 1; c < 5; c++) begin
            wr(8'h38, 4'h1, 32'(c % 4));
            if (c % 4 != 3) begin
                width = 2'(c % 4);
            end
            rd_chk(8'h40, {28'h000_0000, 1'b0, width, 1'b1});
            check({30'h0, bus_width}, {30'h0, width});
        end
        $display("test bus_width done");

        wr(8'h20, 4'h2, 32'h0000_FF00);
        v = card_specific_data(8'hFF);
        rd_chk(8'h20, v[31:0]);
        wr(8'h20, 4'h2, 32'h0000_0000);
        v = card_specific_data(8'h60);
        rd_chk(8'h20, v[31:0]);
        wr(8'h20, 4'h1, 32'h0000_0055);
        rd_chk(8'h20, {v[31:8], 8'h55});
        rd_chk(8'h40, 32'h0000_0009);
        wr(8'h20, 4'h2, 32'h0000_FF00);
        v = card_specific_data(8'hFF);
        rd_chk(8'h20, {v[31:8], 8'h55});
        wr(8'h3C, 4'h1, 32'h0000_0001);
        reg_chk(8'h20, card_specific_data(8'hEC));
        rd_chk(8'h40, 32'h0000_0001);
        $display("test programming done");

        wr(8'h38, 4'h1, 32'h0000_0002);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(8'h40, 32'h0000_0000);
        check({30'h0, bus_width}, 32'h0000_0000);
        rd_chk(8'h00, 32'h40FF_8080);
        v = card_specific_data(8'h00);
        rd_chk(8'h20, v[31:0]);
        $display("test second_reset done");
        summarize();
    end
endmodule
